// ==== shared/pdrc_consts.svh ====
// Constants for the power-down and reset control block
`ifndef PDRC_CONSTS_SVH
`define PDRC_CONSTS_SVH
// Register addresses
`define PDRC_ADDR_BOR_CTRL 8'h86
`define PDRC_ADDR_PWR_CTRL 8'h87
`define PDRC_ADDR_CLK_CTRL 8'h88
`define PDRC_ADDR_CFG 8'h89
// Reset values
`define PDRC_RST_BOR_CTRL 8'h81
`define PDRC_RST_PWR_CTRL 8'h00
`define PDRC_RST_CLK_CTRL 8'h00
// Power control codes
`define PDRC_PWR_IDLE_CODE 8'h01
`define PDRC_PWR_STOP_CODE 8'h03
// Brown-out and clock control register fields
`define PDRC_BOD_EN 0
`define PDRC_BOD_LS_LO 1
`define PDRC_FLAG_BOR 3
`define PDRC_FLAG_DEBUG 4
`define PDRC_FLAG_WATCHDOG 5
`define PDRC_FLAG_PIN 6
`define PDRC_FLAG_POWERON 7
`define PDRC_CLK_LOWFREQ_BIT 7
// Times and derived counts at 125 MHz
`define PDRC_CLK_MHZ 125
`define PDRC_FILT_NS 7000
`define PDRC_FILT_CYC ((`PDRC_FILT_NS * `PDRC_CLK_MHZ + 999) / 1000)
`define PDRC_BOOT_US 12000
`define PDRC_BOOT_CYC (`PDRC_BOOT_US * `PDRC_CLK_MHZ)
`define PDRC_STAB_US 16000
`define PDRC_STAB_CYC (`PDRC_STAB_US * `PDRC_CLK_MHZ)
`define PDRC_SEQ_CYC 5
`define PDRC_RESET_PC 16'h0000
`define PDRC_RESET_ACC 8'h00
`define PDRC_RESET_SP 8'h07
`endif

// ==== shared/pdrc_pkg.sv ====
// Types for the power-down and reset control block
package pdrc_pkg;
   typedef enum logic [2:0] {
      PDRC_BOOT = 3'b000,
      PDRC_CFG = 3'b001,
      PDRC_STAB = 3'b011,
      PDRC_SEQ = 3'b010,
      PDRC_RUN = 3'b110
   } pdrc_rst_t;
   typedef enum logic [1:0] {
      PDRC_ACTIVE = 2'b00,
      PDRC_IDLE = 2'b01,
      PDRC_STOP = 2'b11,
      PDRC_WAKE = 2'b10
   } pdrc_pwr_t;
endpackage

// ==== verilog/pdrc_ctrl.sv ====
// Power-down mode controller and reset generator
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pdrc_consts.svh"

module pdrc_ctrl
   import pdrc_pkg::*;
#(
   parameter int FILT_CYC = `PDRC_FILT_CYC,
   parameter int BOOT_CYC = `PDRC_BOOT_CYC,
   parameter int STAB_CYC = `PDRC_STAB_CYC
) (
   // Clock and power-on reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Reset sources (asynchronous)
   input wire logic reset_pin_n,
   input wire logic watchdog_ovf,
   input wire logic watchdog_enable,
   input wire logic debug_port_reset,
   input wire logic [3:0] bod_below,
   // Interrupt wake request
   input wire logic irq_pending_enabled,
   input wire logic global_interrupt_enable,
   // Configuration option word
   input wire logic [7:0] cfg_option,
   // Outputs
   output logic sys_reset_n,
   output logic cpu_halt,
   output logic main_clk_en,
   output logic periph_clk_en,
   output logic lowfreq_osc_en,
   output logic brownout_det_en,
   output logic [1:0] brownout_level_select,
   output logic [7:0] cfg_value,
   output logic [15:0] cpu_pc_init,
   output logic [7:0] cpu_acc_init,
   output logic [7:0] cpu_sp_init
);
   localparam int CW = 21;
   initial begin
      if (FILT_CYC < 1 || FILT_CYC > 65536 || BOOT_CYC < 1 || STAB_CYC <= BOOT_CYC
          || STAB_CYC >= (1 << CW)) begin
         $error("pdrc_ctrl: counts out of range");
      end
   end

   // Two-flop synchronisers for the reset-source and interrupt inputs; watchdog_enable is used unsynchronised
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic [3:0] bod1_reg;
   logic [3:0] bod2_reg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 5'h01;
         sync2_reg <= 5'h01;
         bod1_reg <= 4'h0;
         bod2_reg <= 4'h0;
      end else begin
         sync1_reg <= {global_interrupt_enable, irq_pending_enabled, debug_port_reset,
                       watchdog_ovf, reset_pin_n};
         sync2_reg <= sync1_reg;
         bod1_reg <= bod_below;
         bod2_reg <= bod1_reg;
      end
   end
   logic pin_s;
   logic wdog_s;
   logic dbg_s;
   logic irq_s;
   logic gie_s;
   assign pin_s = sync2_reg[0];
   assign wdog_s = sync2_reg[1];
   assign dbg_s = sync2_reg[2];
   assign irq_s = sync2_reg[3];
   assign gie_s = sync2_reg[4];

   // Pin noise filter: low must persist FILT_CYC cycles to count
   logic [15:0] filt_cnt_reg;
   logic pin_rst_reg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_cnt_reg <= 16'h0000;
         pin_rst_reg <= 1'b0;
      end else if (pin_s) begin
         filt_cnt_reg <= 16'h0000;
         pin_rst_reg <= 1'b0;
      end else if (filt_cnt_reg >= 16'(FILT_CYC - 1)) begin
         pin_rst_reg <= 1'b1;
      end else begin
         filt_cnt_reg <= filt_cnt_reg + 16'h0001;
      end
   end

   // Registers
   logic [7:0] bor_ctrl_reg;
   logic [7:0] pwr_ctrl_reg;
   logic [7:0] clk_ctrl_reg;
   logic bod_hit;
   logic wdog_hit;
   logic any_rst;
   assign bod_hit = bor_ctrl_reg[`PDRC_BOD_EN] & bod2_reg[bor_ctrl_reg[2:1]];
   assign wdog_hit = wdog_s & watchdog_enable;
   assign any_rst = pin_rst_reg | wdog_hit | dbg_s | bod_hit;

   // Reset sequencer
   pdrc_rst_t rst_st_reg;
   logic [CW-1:0] seq_cnt_reg;
   pdrc_pwr_t pwr_st_reg;
   logic wake_irq;
   // STOP wake needs own and global enable; idle wakes on own enable alone
   assign wake_irq = irq_s & gie_s;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_st_reg <= PDRC_BOOT;
         seq_cnt_reg <= '0;
      end else if (any_rst) begin
         rst_st_reg <= PDRC_STAB;
         seq_cnt_reg <= '0;
      end else begin
         unique case (rst_st_reg)
            PDRC_BOOT: begin
               if (seq_cnt_reg >= CW'(BOOT_CYC - 1)) begin
                  rst_st_reg <= PDRC_CFG;
               end
               seq_cnt_reg <= seq_cnt_reg + 1'b1;
            end
            PDRC_CFG: begin
               rst_st_reg <= PDRC_STAB;
            end
            // Release after 16 ms (counted from detection)
            PDRC_STAB: begin
               if (seq_cnt_reg >= CW'(STAB_CYC - 1)) begin
                  rst_st_reg <= PDRC_SEQ;
                  seq_cnt_reg <= '0;
               end else begin
                  seq_cnt_reg <= seq_cnt_reg + 1'b1;
               end
            end
            PDRC_SEQ: begin
               if (seq_cnt_reg >= CW'(`PDRC_SEQ_CYC - 1)) begin
                  rst_st_reg <= PDRC_RUN;
               end
               seq_cnt_reg <= seq_cnt_reg + 1'b1;
            end
            PDRC_RUN: begin
               // STOP wake reuses the stabilisation count
               if (pwr_st_reg == PDRC_STOP && wake_irq) begin
                  seq_cnt_reg <= '0;
               end else if (pwr_st_reg == PDRC_WAKE) begin
                  seq_cnt_reg <= seq_cnt_reg + 1'b1;
               end
            end
            default: rst_st_reg <= PDRC_BOOT;
         endcase
      end
   end
   logic in_reset;
   assign in_reset = (rst_st_reg != PDRC_RUN) || any_rst;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_value <= 8'h00;
      end else if (rst_st_reg == PDRC_CFG) begin
         cfg_value <= cfg_option;
      end
   end

   // Power mode machine
   logic wr_pwr;
   assign wr_pwr = reg_wr && reg_addr == `PDRC_ADDR_PWR_CTRL;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_st_reg <= PDRC_ACTIVE;
      end else if (in_reset) begin
         pwr_st_reg <= PDRC_ACTIVE;
      end else begin
         unique case (pwr_st_reg)
            PDRC_ACTIVE: begin
               if (wr_pwr && reg_wdata == `PDRC_PWR_IDLE_CODE) begin
                  pwr_st_reg <= PDRC_IDLE;
               end else if (wr_pwr && reg_wdata == `PDRC_PWR_STOP_CODE) begin
                  pwr_st_reg <= PDRC_STOP;
               end
            end
            PDRC_IDLE: if (irq_s) begin
               pwr_st_reg <= PDRC_ACTIVE;
            end
            PDRC_STOP: if (wake_irq) begin
               pwr_st_reg <= PDRC_WAKE;
            end
            PDRC_WAKE: if (seq_cnt_reg >= CW'(STAB_CYC - 1)) begin
               pwr_st_reg <= PDRC_ACTIVE;
            end
         endcase
      end
   end

   // Power control register; cleared on leaving power-down
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_ctrl_reg <= `PDRC_RST_PWR_CTRL;
      end else if (in_reset) begin
         pwr_ctrl_reg <= `PDRC_RST_PWR_CTRL;
      end else if (pwr_st_reg == PDRC_IDLE && irq_s) begin
         pwr_ctrl_reg <= `PDRC_RST_PWR_CTRL;
      end else if (pwr_st_reg == PDRC_STOP && wake_irq) begin
         pwr_ctrl_reg <= `PDRC_RST_PWR_CTRL;
      end else if (wr_pwr && pwr_st_reg == PDRC_ACTIVE) begin
         pwr_ctrl_reg <= reg_wdata;
      end
   end

   // Clock control register; writes only while active
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_ctrl_reg <= `PDRC_RST_CLK_CTRL;
      end else if (in_reset) begin
         clk_ctrl_reg <= `PDRC_RST_CLK_CTRL;
      end else if (reg_wr && reg_addr == `PDRC_ADDR_CLK_CTRL && pwr_st_reg == PDRC_ACTIVE) begin
         clk_ctrl_reg <= reg_wdata;
      end
   end

   // Brown-out control and reset flags; set wins over software clear
   logic wr_bor;
   logic por_evt;
   assign wr_bor = reg_wr && reg_addr == `PDRC_ADDR_BOR_CTRL;
   assign por_evt = rst_st_reg == PDRC_CFG;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bor_ctrl_reg <= `PDRC_RST_BOR_CTRL;
      end else begin
         if (wr_bor) begin
            bor_ctrl_reg[2:0] <= reg_wdata[2:0];
            bor_ctrl_reg[7:3] <= bor_ctrl_reg[7:3] & reg_wdata[7:3];
         end else if (in_reset) begin
            bor_ctrl_reg[2:0] <= 3'(`PDRC_RST_BOR_CTRL);
         end
         if (por_evt) begin
            bor_ctrl_reg[`PDRC_FLAG_POWERON] <= 1'b1;
            bor_ctrl_reg[6:3] <= 4'h0;
         end
         if (pin_rst_reg) bor_ctrl_reg[`PDRC_FLAG_PIN] <= 1'b1;
         if (wdog_hit) bor_ctrl_reg[`PDRC_FLAG_WATCHDOG] <= 1'b1;
         if (dbg_s) bor_ctrl_reg[`PDRC_FLAG_DEBUG] <= 1'b1;
         if (bod_hit) bor_ctrl_reg[`PDRC_FLAG_BOR] <= 1'b1;
      end
   end

   // Read port, one cycle latency
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `PDRC_ADDR_BOR_CTRL: reg_rdata <= bor_ctrl_reg;
            `PDRC_ADDR_PWR_CTRL: reg_rdata <= pwr_ctrl_reg;
            `PDRC_ADDR_CLK_CTRL: reg_rdata <= clk_ctrl_reg;
            `PDRC_ADDR_CFG: reg_rdata <= cfg_value;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Registered outputs; the stop variant follows clock control bit 7
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_reset_n <= 1'b0;
         cpu_halt <= 1'b0;
         main_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         lowfreq_osc_en <= 1'b1;
         brownout_det_en <= 1'b1;
         brownout_level_select <= 2'b00;
         cpu_pc_init <= `PDRC_RESET_PC;
         cpu_acc_init <= `PDRC_RESET_ACC;
         cpu_sp_init <= `PDRC_RESET_SP;
      end else begin
         sys_reset_n <= !in_reset;
         // CPU halts, clocks run in idle
         cpu_halt <= pwr_st_reg != PDRC_ACTIVE;
         // Main and peripheral clocks stop in STOP
         main_clk_en <= pwr_st_reg != PDRC_STOP;
         periph_clk_en <= pwr_st_reg != PDRC_STOP;
         lowfreq_osc_en <= pwr_st_reg != PDRC_STOP || clk_ctrl_reg[`PDRC_CLK_LOWFREQ_BIT];
         brownout_det_en <= bor_ctrl_reg[`PDRC_BOD_EN];
         brownout_level_select <= bor_ctrl_reg[2:1];
         cpu_pc_init <= `PDRC_RESET_PC;
         cpu_acc_init <= `PDRC_RESET_ACC;
         cpu_sp_init <= `PDRC_RESET_SP;
      end
   end

   // Checks
   sequence s_stop_write;
      wr_pwr && reg_wdata == `PDRC_PWR_STOP_CODE && pwr_st_reg == PDRC_ACTIVE && !in_reset;
   endsequence
   a_idle_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_pwr && reg_wdata == `PDRC_PWR_IDLE_CODE && pwr_st_reg == PDRC_ACTIVE && !in_reset
      |=> pwr_st_reg == PDRC_IDLE ##1 cpu_halt)
      else $error("idle not entered");
   a_stop_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_stop_write |=> pwr_st_reg == PDRC_STOP ##1 !main_clk_en)
      else $error("stop not entered");
   a_other_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_pwr && reg_wdata != `PDRC_PWR_IDLE_CODE && reg_wdata != `PDRC_PWR_STOP_CODE
      && pwr_st_reg == PDRC_ACTIVE |=> pwr_st_reg == PDRC_ACTIVE)
      else $error("bad code started power-down");
   a_stop_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pwr_st_reg == PDRC_STOP && wake_irq && !in_reset |=> pwr_ctrl_reg == 8'h00)
      else $error("power control not cleared");
   a_stop_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pwr_st_reg == PDRC_STOP && !in_reset && !wake_irq |=> $stable(clk_ctrl_reg))
      else $error("register changed in stop");
   a_lowfreq_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pwr_st_reg == PDRC_STOP && !clk_ctrl_reg[7] |=> !lowfreq_osc_en)
      else $error("low frequency oscillator not stopped");
   a_por_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      bor_ctrl_reg[7] && !(wr_bor && !reg_wdata[7]) |=> bor_ctrl_reg[7])
      else $error("power-on flag lost");
   a_pin_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pin_rst_reg |=> bor_ctrl_reg[6] ##1 !sys_reset_n)
      else $error("pin flag not set");
   a_seq_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rst_st_reg == PDRC_STAB && $past(rst_st_reg) != PDRC_STAB && !any_rst
      |-> !sys_reset_n)
      else $error("early release");
endmodule
`default_nettype wire

// ==== dv/pdrc_ctrl_bench.sv ====
// Self-checking bench for the power-down and reset controller
`timescale 1ns/1ps
`default_nettype none
`include "pdrc_consts.svh"
module pdrc_ctrl_bench;
   // Shortened counts keep each reset sequence to a few dozen cycles
   localparam int FILT = 4;
   localparam int BOOT = 20;
   localparam int STAB = 30;
   logic sys_clk, rst_n, reg_wr, reg_rd, reset_pin_n, watchdog_ovf, watchdog_enable;
   logic debug_port_reset, irq_pending_enabled, global_interrupt_enable;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg_option, cfg_value, cpu_acc_init, cpu_sp_init;
   logic [3:0] bod_below;
   logic sys_reset_n, cpu_halt, main_clk_en, periph_clk_en, lowfreq_osc_en, brownout_det_en;
   logic [1:0] brownout_level_select;
   logic [15:0] cpu_pc_init;
   int bad_count, cmp_count;
   int n;
   pdrc_ctrl #(.FILT_CYC(FILT), .BOOT_CYC(BOOT), .STAB_CYC(STAB)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_pin_n(reset_pin_n),
      .watchdog_ovf(watchdog_ovf), .watchdog_enable(watchdog_enable),
      .debug_port_reset(debug_port_reset), .bod_below(bod_below),
      .irq_pending_enabled(irq_pending_enabled),
      .global_interrupt_enable(global_interrupt_enable), .cfg_option(cfg_option),
      .sys_reset_n(sys_reset_n), .cpu_halt(cpu_halt), .main_clk_en(main_clk_en),
      .periph_clk_en(periph_clk_en), .lowfreq_osc_en(lowfreq_osc_en),
      .brownout_det_en(brownout_det_en), .brownout_level_select(brownout_level_select),
      .cfg_value(cfg_value), .cpu_pc_init(cpu_pc_init), .cpu_acc_init(cpu_acc_init),
      .cpu_sp_init(cpu_sp_init));
   // 125 MHz system clock
   always #4 sys_clk = ~sys_clk;
   // Verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Reads right after an edge see what settled in the cycle before it
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   // One-cycle write strobe; the task returns as soon as the strobe is dropped
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data is looked at only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      chk(what, {8'h00, reg_rdata}, {8'h00, exp});
   endtask
   // Bounded wait for a level on sys_reset_n or cpu_halt, cycles counted in n
   task automatic wait_for(input bit on_halt, input int lim);
      n = 0;
      while ((on_halt ? cpu_halt : ~sys_reset_n) !== 1'b0) begin
         cyc(1);
         n++;
         if (n > lim) begin
            bad_count++;
            $display("MISMATCH wait expected done seen timeout");
            summarize();
         end
      end
   endtask
   task automatic t_por();
      @(posedge sys_clk);
      rst_n <= 1'b0;
      cyc(16);
      chk("rst_low", sys_reset_n, 0);
      chk("clk_in_rst", {main_clk_en, periph_clk_en, brownout_det_en}, 3'b111);
      rst_n <= 1'b1;
      wait_for(0, 200);
      // boot wait lies inside the release count taken from detection
      chk("boot_len", n >= STAB + 6 && n <= STAB + 9, 1);
      chk("pc", cpu_pc_init, 16'h0000);
      chk("acc_sp", {cpu_acc_init, cpu_sp_init}, 16'h0007);
      chk("cfg", cfg_value, 8'h5A);
      rd(`PDRC_ADDR_CFG, 8'h5A, "cfg_rd");
      rd(`PDRC_ADDR_BOR_CTRL, 8'h81, "bor_por");
      rd(`PDRC_ADDR_PWR_CTRL, 8'h00, "pwr_rst");
      rd(8'h90, 8'h00, "unmapped");
   endtask
   task automatic t_levels();
      for (int lv = 0; lv < 4; lv++) begin
         wr(`PDRC_ADDR_BOR_CTRL, {1'b1, 4'h0, lv[1:0], 1'b1});
         cyc(2);
         chk("bod_level", brownout_level_select, lv[1:0]);
         rd(`PDRC_ADDR_BOR_CTRL, {1'b1, 4'h0, lv[1:0], 1'b1}, "bor_lv");
      end
      wr(`PDRC_ADDR_BOR_CTRL, 8'h00);
      cyc(2);
      chk("bod_off", brownout_det_en, 0);
      wr(`PDRC_ADDR_BOR_CTRL, 8'h01);
      cyc(2);
      chk("bod_on", brownout_det_en, 1);
      rd(`PDRC_ADDR_BOR_CTRL, 8'h01, "poweron_reset_flag_clr");
   endtask
   task automatic t_other_codes();
      logic [7:0] codes [4] = '{8'h02, 8'h04, 8'hFF, 8'h00};
      foreach (codes[i]) begin
         wr(`PDRC_ADDR_PWR_CTRL, codes[i]);
         cyc(3);
         chk("no_mode", {cpu_halt, main_clk_en}, 2'b01);
      end
   endtask
   task automatic t_idle();
      wr(`PDRC_ADDR_PWR_CTRL, 8'h01);
      cyc(2);
      chk("idle", {cpu_halt, main_clk_en, periph_clk_en}, 3'b111);
      // Global enable left low: an individually enabled source wakes idle alone
      irq_pending_enabled <= 1'b1;
      wait_for(1, 12);
      chk("idle_exit", cpu_halt, 0);
      irq_pending_enabled <= 1'b0;
      cyc(2);
   endtask
   task automatic t_deep_sleep_lowfreq_on();
      wr(`PDRC_ADDR_CLK_CTRL, 8'h80);
      wr(`PDRC_ADDR_PWR_CTRL, 8'h03);
      cyc(2);
      chk("deep_sleep_lowfreq_on", {cpu_halt, main_clk_en, periph_clk_en, lowfreq_osc_en}, 4'b1001);
      rd(`PDRC_ADDR_PWR_CTRL, 8'h03, "pwr_stop");
      rd(`PDRC_ADDR_BOR_CTRL, 8'h01, "bor_held");
      irq_pending_enabled <= 1'b1;
      cyc(10);
      chk("no_wake", {cpu_halt, main_clk_en}, 2'b10);
      global_interrupt_enable <= 1'b1;
      wait_for(1, STAB + 20);
      chk("stab", n >= STAB, 1);
      chk("woke", {main_clk_en, periph_clk_en}, 2'b11);
      irq_pending_enabled <= 1'b0;
      global_interrupt_enable <= 1'b0;
      rd(`PDRC_ADDR_PWR_CTRL, 8'h00, "pwr_clr_irq");
      rd(`PDRC_ADDR_CLK_CTRL, 8'h80, "clk_kept");
   endtask
   task automatic t_filter();
      // Pulse shorter than the filter count must not reach the core
      reset_pin_n <= 1'b0;
      cyc(2);
      reset_pin_n <= 1'b1;
      cyc(10);
      chk("filtered", sys_reset_n, 1);
   endtask
   task automatic t_deep_sleep_lowfreq_off_pin();
      // detector switched off before stop for lowest current
      wr(`PDRC_ADDR_BOR_CTRL, 8'h00);
      wr(`PDRC_ADDR_CLK_CTRL, 8'h00);
      wr(`PDRC_ADDR_PWR_CTRL, 8'h03);
      cyc(2);
      chk("deep_sleep_lowfreq_off", {main_clk_en, lowfreq_osc_en}, 2'b00);
      // pin held low beyond the filter
      reset_pin_n <= 1'b0;
      cyc(FILT + 6);
      chk("pin_rst", sys_reset_n, 0);
      reset_pin_n <= 1'b1;
      wait_for(0, STAB + 40);
      chk("pin_stab", n >= STAB, 1);
      chk("pin_run", cpu_halt, 0);
      rd(`PDRC_ADDR_PWR_CTRL, 8'h00, "pwr_clr_rst");
      rd(`PDRC_ADDR_CLK_CTRL, 8'h00, "clk_rst");
      rd(`PDRC_ADDR_BOR_CTRL, 8'h41, "pin_flag");
   endtask
   task automatic t_sources();
      logic [7:0] exp;
      // Gated sources: detector off, watchdog disabled
      wr(`PDRC_ADDR_BOR_CTRL, 8'h00);
      bod_below <= 4'h1;
      watchdog_ovf <= 1'b1;
      cyc(20);
      chk("gated", sys_reset_n, 1);
      bod_below <= 4'h0;
      watchdog_ovf <= 1'b0;
      exp = 8'h01;
      for (int s = 0; s < 3; s++) begin
         cyc(2);
         case (s)
            0: watchdog_enable <= 1'b1;
            1: debug_port_reset <= 1'b1;
            default: bod_below <= 4'h1;
         endcase
         watchdog_ovf <= (s == 0);
         cyc(6);
         chk("src_rst", sys_reset_n, 0);
         watchdog_ovf <= 1'b0;
         watchdog_enable <= 1'b0;
         debug_port_reset <= 1'b0;
         bod_below <= 4'h0;
         wait_for(0, STAB + 40);
         exp = exp | (s == 0 ? 8'h20 : s == 1 ? 8'h10 : 8'h08);
         rd(`PDRC_ADDR_BOR_CTRL, exp, "src_flag");
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reset_pin_n = 1'b1;
      watchdog_ovf = 1'b0;
      watchdog_enable = 1'b0;
      debug_port_reset = 1'b0;
      bod_below = 4'h0;
      irq_pending_enabled = 1'b0;
      global_interrupt_enable = 1'b0;
      cfg_option = 8'h5A;
      bad_count = 0;
      cmp_count = 0;
      t_por();
      t_levels();
      t_other_codes();
      t_idle();
      t_deep_sleep_lowfreq_on();
      t_filter();
      t_deep_sleep_lowfreq_off_pin();
      t_sources();
      // Power-on clears every other flag and sets its own
      t_por();
      wr(`PDRC_ADDR_BOR_CTRL, 8'h7F);
      rd(`PDRC_ADDR_BOR_CTRL, 8'h07, "write_keeps");
      summarize();
   end
endmodule
`default_nettype wire
